//--- tmpa_top.sv
// Mode switching, address matching, mailbox timeout and packet assembly
//
// The implementer's own choices: the APB slave port and the register offsets.
`include "tmpa_map.svh"

// How it works
// - When time stamping is on, each reported monitored frame requests a stamp; default off.
// - Mailbox idle timeout holds 0 to 250 tens of seconds, default 30.
// - Remote mailbox user is dropped after that many idle ticks, never at 0; local operator never.
// - Idle time counts a free-running ten second tick, so it may fire early.
// - Station callsign and substation ID form the source of every originated packet.
// - Frames to the station call are accepted; digipeat naming it is relayed.
// - Alias callsign matches only for relaying, never for connections.
// - Mailbox answers when its call equals the station call; blank refuses all.
// - Without early switching, data mode starts at link up and persists after.
// - With early switching, data mode starts at connect; link loss returns command.
// - Manual-only switching changes modes solely on user commands.
// - CR enable sends the configured count of null bytes after each CR.
// - LF enable sends the configured count of null bytes after each LF.
// - Null count holds 0 to 30, default zero; pads only where enabled.
// - Null padding happens in command or interactive mode, never raw.
// - Data modes send a packet when input reaches the length; 0 means 256.
module tmpa_top #(
  parameter int unsigned TICK_CYCLES = `TMPA_TICK_SEC * `TMPA_CLK_HZ
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_addr_valid,
  input  wire tmpa_pkg::tmpa_call_t rx_dest,
  input  wire tmpa_pkg::tmpa_call_t rx_digi,
  output logic             frame_accept,
  output logic             frame_relay,
  input  wire logic        inc_connect,
  input  wire tmpa_pkg::tmpa_call_t inc_dest,
  output logic             conn_accept,
  output logic             mbox_answer,
  output logic             mbox_refuse,
  output tmpa_pkg::tmpa_call_t tx_source,
  input  wire logic        link_up,
  input  wire logic        link_down,
  input  wire logic        connect_fail,
  output logic             connect_request,
  input  wire logic        mbox_local_login,
  input  wire logic        mbox_activity,
  output logic             mbox_disconnect,
  input  wire logic        mon_frame,
  output logic             mon_stamp,
  input  wire logic        term_in_valid,
  input  wire logic [7:0]  term_in_data,
  output logic             pkt_valid,
  output logic [7:0]       pkt_data,
  output logic             pkt_send,
  output logic             pkt_hold,
  output logic [1:0]       type_in_mode,
  input  wire logic        term_src_valid,
  input  wire logic [7:0]  term_src_data,
  output logic             term_src_ready,
  output logic             term_out_valid,
  output logic [7:0]       term_out_data,
  input  wire logic        term_out_ready
);
  import tmpa_pkg::*;

  logic [5:0]  ctrl;
  logic [7:0]  mbox_tmo;
  logic [4:0]  null_count;
  logic [7:0]  payload_len;
  tmpa_call_t  call_id [3];
  logic        wr_en;
  logic        rd_setup;
  logic        cmd_wr;
  logic [31:0] next_rdata;
  logic        next_err;
  tmpa_mode_e  mode;
  tmpa_mode_e  next_mode;
  tmpa_mode_e  data_mode;
  logic        linked;
  logic        pending;
  logic        mbox_remote;
  logic        mbox_local;
  logic [7:0]  idle_ticks;
  logic [29:0] tick_div;
  logic        tick;
  logic [8:0]  pkt_count;
  logic [8:0]  pkt_limit;
  logic        mbox_open;
  logic        idle_expired;

  // APB access phase completes in the cycle after setup
  assign rd_setup = psel & !penable & !pready;
  assign wr_en    = psel & penable & pready & pwrite;
  assign cmd_wr   = wr_en & (paddr == `TMPA_OFS_COMMAND);

  // Registered ready, one access cycle per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= rd_setup;
      pslverr <= rd_setup & next_err;
      prdata  <= rd_setup ? next_rdata : 32'h0000_0000;
    end
  end

  // Read decode; unmapped or unaligned offsets answer with an error
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      next_err = 1'b1;
    end else if (paddr == `TMPA_OFS_CTRL) begin
      next_rdata = {26'h0, ctrl};
    end else if (paddr == `TMPA_OFS_MBOX_TMO) begin
      next_rdata = {24'h0, mbox_tmo};
    end else if (paddr == `TMPA_OFS_NULLS) begin
      next_rdata = {27'h0, null_count};
    end else if (paddr == `TMPA_OFS_PAYLOAD) begin
      next_rdata = {24'h0, payload_len};
    end else if (paddr >= `TMPA_OFS_CALL_BASE && paddr < `TMPA_OFS_CALL_END) begin
      for (int i = 0; i < 3; i++) begin
        if (paddr == `TMPA_OFS_CALL_BASE + 8'(i) * `TMPA_OFS_CALL_STEP) begin
          next_rdata = call_id[i][31:0];
        end else if (paddr == `TMPA_OFS_CALL_BASE + 8'(i) * `TMPA_OFS_CALL_STEP + 8'h04) begin
          next_rdata = {12'h000, call_id[i][51:32]};
        end
      end
    end else if (paddr == `TMPA_OFS_COMMAND) begin
      next_rdata = 32'h0000_0000;
    end else if (paddr == `TMPA_OFS_STATUS) begin
      next_rdata = {16'h0, idle_ticks, 2'h0, mbox_local, mbox_remote, pending, linked, mode};
    end else begin
      next_err = 1'b1;
    end
  end

  // Settings, restored to defaults by reset; out-of-range values clamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl        <= `TMPA_RST_CTRL;
      mbox_tmo    <= `TMPA_RST_MBOX_TMO;
      null_count  <= `TMPA_RST_NULLS;
      payload_len <= `TMPA_RST_PAYLOAD;
    end else if (wr_en) begin
      if (paddr == `TMPA_OFS_CTRL) begin
        ctrl <= pwdata[5:0];
      end
      if (paddr == `TMPA_OFS_MBOX_TMO) begin
        mbox_tmo <= (pwdata[7:0] > `TMPA_MAX_MBOX_TMO) ? `TMPA_MAX_MBOX_TMO : pwdata[7:0];
      end
      if (paddr == `TMPA_OFS_NULLS) begin
        null_count <= (pwdata[4:0] > `TMPA_MAX_NULLS) ? `TMPA_MAX_NULLS : pwdata[4:0];
      end
      if (paddr == `TMPA_OFS_PAYLOAD) begin
        payload_len <= pwdata[7:0];
      end
    end
  end

  // Station, alias and mailbox callsigns, two words per entry
  for (genvar g = 0; g < 3; g++) begin : g_call
    localparam logic [7:0] LO = `TMPA_OFS_CALL_BASE + 8'(g) * `TMPA_OFS_CALL_STEP;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        call_id[g] <= (g == 0) ? `TMPA_RST_STATION : `TMPA_RST_BLANK;
      end else if (wr_en && paddr == LO) begin
        call_id[g][31:0] <= pwdata;
      end else if (wr_en && paddr == LO + 8'h04) begin
        call_id[g][51:32] <= pwdata[19:0];
      end
    end
  end

  // Received address matching; alias serves relaying only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_accept <= 1'b0;
      frame_relay  <= 1'b0;
      tx_source    <= `TMPA_RST_STATION;
    end else begin
      frame_accept <= rx_addr_valid & (rx_dest == call_id[0]);
      frame_relay  <= rx_addr_valid & ((rx_digi == call_id[0]) |
                      ((call_id[1][47:0] != 48'h0) & (rx_digi == call_id[1])));
      tx_source    <= call_id[0];
    end
  end

  // Incoming connections: station call only, mailbox if calls agree
  assign mbox_open = (call_id[2][47:0] != 48'h0) & (call_id[2] == call_id[0]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conn_accept <= 1'b0;
      mbox_answer <= 1'b0;
      mbox_refuse <= 1'b0;
    end else begin
      conn_accept <= inc_connect & (inc_dest == call_id[0]);
      mbox_answer <= inc_connect & (inc_dest == call_id[0]) & mbox_open;
      mbox_refuse <= inc_connect & (inc_dest == call_id[0]) & !mbox_open;
    end
  end

  // Free-running ten second tick, never restarted by activity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_div <= 30'h0;
      tick     <= 1'b0;
    end else if (tick_div == 30'(TICK_CYCLES - 1)) begin
      tick_div <= 30'h0;
      tick     <= 1'b1;
    end else begin
      tick_div <= tick_div + 30'h1;
      tick     <= 1'b0;
    end
  end

  // Mailbox sessions and the idle timeout for remote users
  assign idle_expired = tick & (mbox_tmo != 8'h00) & (idle_ticks + 8'h01 >= mbox_tmo);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mbox_remote     <= 1'b0;
      mbox_local      <= 1'b0;
      idle_ticks      <= 8'h00;
      mbox_disconnect <= 1'b0;
    end else begin
      mbox_disconnect <= 1'b0;
      if (mbox_local_login) begin
        mbox_local <= 1'b1; // local operator is never timed out
      end
      if (mbox_answer || mbox_activity) begin
        idle_ticks <= 8'h00;
        mbox_remote <= mbox_remote | mbox_answer;
      end else if (link_down) begin
        mbox_remote <= 1'b0;
        mbox_local  <= 1'b0;
        idle_ticks  <= 8'h00;
      end else if (mbox_remote && idle_expired) begin
        mbox_remote     <= 1'b0;
        mbox_disconnect <= 1'b1;
        idle_ticks      <= 8'h00;
      end else if (mbox_remote && tick && idle_ticks != 8'hFF) begin
        idle_ticks <= idle_ticks + 8'h01;
      end
    end
  end

  // Link and connect attempt flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      linked          <= 1'b0;
      pending         <= 1'b0;
      connect_request <= 1'b0;
    end else begin
      connect_request <= cmd_wr & pwdata[`TMPA_CMD_CONNECT];
      if (link_up) begin
        linked  <= 1'b1;
        pending <= 1'b0;
      end else if (link_down || connect_fail) begin
        linked  <= 1'b0;
        pending <= 1'b0;
      end else if (cmd_wr && pwdata[`TMPA_CMD_CONNECT]) begin
        pending <= 1'b1;
      end
    end
  end

  // Mode choice: user commands first, then automatic switching
  assign data_mode = ctrl[`TMPA_CTRL_CONNECT_DATA_MODE_SELECT] ? TMPA_RAW : TMPA_INTER;
  always_comb begin
    next_mode = mode;
    if (cmd_wr && pwdata[`TMPA_CMD_COMMAND]) begin
      next_mode = TMPA_CMD;
    end else if (cmd_wr && pwdata[`TMPA_CMD_INTER]) begin
      next_mode = TMPA_INTER;
    end else if (cmd_wr && pwdata[`TMPA_CMD_RAW]) begin
      next_mode = TMPA_RAW;
    end else if (!ctrl[`TMPA_CTRL_MANUAL]) begin
      if (ctrl[`TMPA_CTRL_EARLY]) begin
        if (cmd_wr && pwdata[`TMPA_CMD_CONNECT]) begin
          next_mode = data_mode;
        end else if (link_down || connect_fail) begin
          next_mode = TMPA_CMD;
        end
      end else if (link_up) begin
        next_mode = data_mode;
      end
    end
  end

  // Mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode         <= TMPA_CMD;
      type_in_mode <= 2'b00;
    end else begin
      unique case (next_mode)
        TMPA_CMD, TMPA_INTER, TMPA_RAW: mode <= next_mode;
        default: mode <= TMPA_CMD;
      endcase
      type_in_mode <= next_mode;
    end
  end

  // Packet assembly in data modes; send at the length limit
  assign pkt_limit = (payload_len == 8'h00) ? 9'h100 : {1'b0, payload_len};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_count <= 9'h000;
      pkt_valid <= 1'b0;
      pkt_data  <= 8'h00;
      pkt_send  <= 1'b0;
      pkt_hold  <= 1'b0;
    end else begin
      pkt_valid <= 1'b0;
      pkt_send  <= 1'b0;
      pkt_hold  <= pending & ctrl[`TMPA_CTRL_EARLY]; // queued until link completes
      if (mode == TMPA_CMD) begin
        pkt_count <= 9'h000;
      end else if (term_in_valid) begin
        pkt_valid <= 1'b1;
        pkt_data  <= term_in_data;
        if (pkt_count + 9'h001 == pkt_limit) begin
          pkt_send  <= 1'b1;
          pkt_count <= 9'h000;
        end else begin
          pkt_count <= pkt_count + 9'h001;
        end
      end
    end
  end

  // Monitored frames request a date and time stamp when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_stamp <= 1'b0;
    end else begin
      mon_stamp <= mon_frame & ctrl[`TMPA_CTRL_STAMP];
    end
  end

  // Terminal output with null padding
  tmpa_pad u_pad (
    .pclk       (pclk),
    .presetn    (presetn),
    .pad_cr     (ctrl[`TMPA_CTRL_PAD_CR]),
    .pad_lf     (ctrl[`TMPA_CTRL_PAD_LF]),
    .null_count (null_count),
    .raw_mode   (mode == TMPA_RAW),
    .src_valid  (term_src_valid),
    .src_data   (term_src_data),
    .src_ready  (term_src_ready),
    .out_valid  (term_out_valid),
    .out_data   (term_out_data),
    .out_ready  (term_out_ready)
  );
endmodule

//--- tmpa_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef TMPA_MAP_SVH
`define TMPA_MAP_SVH
`define TMPA_OFS_CTRL       8'h00
`define TMPA_OFS_MBOX_TMO   8'h04
`define TMPA_OFS_NULLS      8'h08
`define TMPA_OFS_PAYLOAD    8'h0C
`define TMPA_OFS_CALL_BASE  8'h10
`define TMPA_OFS_CALL_STEP  8'h08
`define TMPA_OFS_CALL_END   8'h28
`define TMPA_OFS_COMMAND    8'h28
`define TMPA_OFS_STATUS     8'h2C
`define TMPA_CTRL_STAMP     0
`define TMPA_CTRL_EARLY     1
`define TMPA_CTRL_MANUAL    2
`define TMPA_CTRL_PAD_CR    3
`define TMPA_CTRL_PAD_LF    4
`define TMPA_CTRL_CONNECT_DATA_MODE_SELECT   5
`define TMPA_CMD_CONNECT    0
`define TMPA_CMD_INTER      1
`define TMPA_CMD_RAW        2
`define TMPA_CMD_COMMAND    3
`define TMPA_RST_CTRL       6'h00
`define TMPA_RST_MBOX_TMO   8'h1E
`define TMPA_MAX_MBOX_TMO   8'hFA
`define TMPA_RST_NULLS      5'h00
`define TMPA_MAX_NULLS      5'h1E
`define TMPA_RST_PAYLOAD    8'h80
`define TMPA_RST_STATION    52'h0_4E4F43414C4C
`define TMPA_RST_BLANK      52'h0_000000000000
`define TMPA_CHAR_CR        8'h0D
`define TMPA_CHAR_LF        8'h0A
`define TMPA_CHAR_NULL      8'h00
`define TMPA_CLK_HZ         100000000
`define TMPA_TICK_SEC       10
`endif

//--- tmpa_pkg.sv
// Types shared by the mode and packet assembly block
package tmpa_pkg;
  // Terminal type-in mode, Gray coded along command, interactive, raw
  typedef enum logic [1:0] {
    TMPA_CMD   = 2'b00,
    TMPA_INTER = 2'b01,
    TMPA_RAW   = 2'b11
  } tmpa_mode_e;
  // Callsign of six ASCII characters plus a four bit substation ID
  typedef logic [51:0] tmpa_call_t;
endpackage

//--- tmpa_pad.sv
// Terminal output stage that inserts null padding after CR and LF
`include "tmpa_map.svh"
module tmpa_pad (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       pad_cr,
  input  wire logic       pad_lf,
  input  wire logic [4:0] null_count,
  input  wire logic       raw_mode,
  input  wire logic       src_valid,
  input  wire logic [7:0] src_data,
  output logic            src_ready,
  output logic            out_valid,
  output logic [7:0]      out_data,
  input  wire logic       out_ready
);
  logic [4:0] nulls_left;
  logic       accept;
  logic       wants_pad;

  // Pad only after CR or LF, only when enabled and never in raw mode
  assign accept    = src_valid & src_ready;
  assign wants_pad = !raw_mode & ((pad_cr & (src_data == `TMPA_CHAR_CR)) |
                                  (pad_lf & (src_data == `TMPA_CHAR_LF)));

  // One byte in flight, followed by its nulls; source stalls meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid  <= 1'b0;
      out_data   <= 8'h00;
      nulls_left <= 5'h00;
      src_ready  <= 1'b0;
    end else if (accept) begin
      out_valid  <= 1'b1;
      out_data   <= src_data;
      nulls_left <= wants_pad ? null_count : 5'h00;
      src_ready  <= 1'b0;
    end else if (out_valid && out_ready) begin
      if (nulls_left != 5'h00) begin
        out_data   <= `TMPA_CHAR_NULL;
        nulls_left <= nulls_left - 5'h01;
      end else begin
        out_valid <= 1'b0;
      end
    end else if (!out_valid) begin
      src_ready <= 1'b1;
    end
  end
endmodule

//--- tmpa_host_model.sv
// Terminal model that takes padded output and stalls now and then
module tmpa_host_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  output logic            out_ready,
  output int              n_bytes,
  output int              n_nulls
);
  timeunit 1ns / 1ps;
  logic [1:0] phase;
  // Ready drops one cycle in three, as a slow terminal would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase     <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      phase     <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      out_ready <= (phase != 2'h2);
    end
  end
  // Count every byte taken, and the nulls among them
  always_ff @(posedge pclk) begin
    if (out_valid && out_ready) begin
      n_bytes <= n_bytes + 1;
      n_nulls <= n_nulls + int'(out_data == 8'h00);
    end
  end
endmodule

//--- tmpa_top_chk.sv
// Port checks for the mode and packet assembly block
`include "tmpa_map.svh"
module tmpa_top_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic       pready,
  input wire logic       rx_addr_valid,
  input wire logic       frame_accept,
  input wire logic       frame_relay,
  input wire logic       inc_connect,
  input wire logic       conn_accept,
  input wire logic       mbox_answer,
  input wire logic       mon_frame,
  input wire logic       mon_stamp,
  input wire logic       term_in_valid,
  input wire logic       pkt_valid,
  input wire logic       pkt_send,
  input wire logic [1:0] type_in_mode,
  input wire logic       connect_request,
  input wire logic       term_out_valid,
  input wire logic [7:0] term_out_data,
  input wire logic       term_out_ready
);
  timeunit 1ns / 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed write of the connect bit to the command word
  logic wr_conn;
  assign wr_conn = psel && penable && pready && pwrite && (paddr == `TMPA_OFS_COMMAND) && pwdata[`TMPA_CMD_CONNECT];
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  chk_apb_ready:
    assert property (s_setup |=> s_access ##1 !pready) else $error("ready not one cycle after setup");
  chk_stamp_cause:
    assert property (mon_stamp |-> $past(mon_frame)) else $error("stamp without monitored frame");
  chk_accept_cause:
    assert property (frame_accept |-> $past(rx_addr_valid)) else $error("accept without frame");
  chk_relay_cause:
    assert property (frame_relay |-> $past(rx_addr_valid)) else $error("relay without frame");
  chk_answer_conn:
    assert property (mbox_answer |-> conn_accept && $past(inc_connect)) else $error("answer without connect");
  chk_pkt_mode:
    assert property (pkt_valid |-> $past(term_in_valid) && $past(type_in_mode) != 2'b00) else $error("byte in command");
  chk_send_byte:
    assert property (pkt_send |-> pkt_valid) else $error("send without byte");
  chk_conn_req:
    assert property (connect_request == $past(wr_conn)) else $error("connect request timing");
  chk_out_hold:
    assert property (term_out_valid && !term_out_ready |=> term_out_valid && $stable(term_out_data))
      else $error("terminal byte dropped under stall");
endmodule
bind tmpa_top tmpa_top_chk tmpa_top_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .rx_addr_valid(rx_addr_valid), .frame_accept(frame_accept),
  .frame_relay(frame_relay), .inc_connect(inc_connect), .conn_accept(conn_accept), .mbox_answer(mbox_answer),
  .mon_frame(mon_frame), .mon_stamp(mon_stamp), .term_in_valid(term_in_valid), .pkt_valid(pkt_valid),
  .pkt_send(pkt_send), .type_in_mode(type_in_mode), .connect_request(connect_request),
  .term_out_valid(term_out_valid), .term_out_data(term_out_data), .term_out_ready(term_out_ready)
);

//--- tmpa_top_bench.sv
// Self-checking bench for the mode and packet assembly block
module tmpa_top_bench;
  timeunit 1ns / 1ps;
  import tmpa_pkg::*;
  localparam tmpa_call_t STA = 52'h3_4546_41424344;
  localparam tmpa_call_t ALS = 52'h1_4141_52454C59;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, tsv, tsr, pkt_hold, ov, orr, err;
  logic [7:0]  paddr, tsd, od, tid, pd;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0]  stb, pul;
  logic [1:0]  mode;
  tmpa_call_t  rx_dest, rx_digi, inc_dest, tx_source;
  int          cnt [9], base [9], n_bytes, n_nulls, b0, z0, n_mismatch, n_tests;
  logic [7:0]  da [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
  logic [31:0] dd [7] = '{32'h0, 32'h1E, 32'h0, 32'h80, 32'h43414C4C, 32'h4E4F, 32'h0};

  tmpa_top #(.TICK_CYCLES(20)) tmpa_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_addr_valid(stb[0]),
    .rx_dest(rx_dest), .rx_digi(rx_digi), .frame_accept(pul[0]), .frame_relay(pul[1]),
    .inc_connect(stb[1]), .inc_dest(inc_dest), .conn_accept(pul[2]), .mbox_answer(pul[3]),
    .mbox_refuse(pul[4]), .tx_source(tx_source), .link_up(stb[2]), .link_down(stb[3]),
    .connect_fail(stb[4]), .connect_request(), .mbox_local_login(stb[8]), .mbox_activity(stb[6]),
    .mbox_disconnect(pul[8]), .mon_frame(stb[5]), .mon_stamp(pul[5]), .term_in_valid(stb[7]),
    .term_in_data(tid), .pkt_valid(pul[6]), .pkt_data(pd), .pkt_send(pul[7]), .pkt_hold(pkt_hold),
    .type_in_mode(mode), .term_src_valid(tsv), .term_src_data(tsd), .term_src_ready(tsr),
    .term_out_valid(ov), .term_out_data(od), .term_out_ready(orr)
  );
  tmpa_host_model tmpa_host_model_inst (
    .pclk(pclk), .presetn(presetn), .out_valid(ov), .out_data(od), .out_ready(orr),
    .n_bytes(n_bytes), .n_nulls(n_nulls)
  );

  // Clock and pulse counters
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) foreach (cnt[i]) cnt[i] <= cnt[i] + int'(pul[i]);
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end

  function automatic int dlt(input int i);
    return cnt[i] - base[i];
  endfunction
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic pulse(input int k);
    stb[k] <= 1'b1;
    @(posedge pclk);
    stb[k] <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  // Send one byte to the terminal and count what arrives there
  task automatic send(input logic [7:0] b, input int pads);
    b0 = n_bytes;
    z0 = n_nulls;
    tsd <= b;
    tsv <= 1'b1;
    do @(posedge pclk); while (tsr !== 1'b1);
    tsv <= 1'b0;
    repeat (2) @(posedge pclk);
    while (tsr !== 1'b1) @(posedge pclk);
    check(n_bytes - b0, 1 + pads);
    check(n_nulls - z0, pads);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, tsv, paddr, pwdata, tsd, tid, stb} = '0;
    {rx_dest, rx_digi, inc_dest} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (da[i]) begin
      apb(1'b0, da[i], 32'h0);
      check(rd, dd[i]);
    end
    check(tx_source, 52'h0_4E4F43414C4C);
    // Clamping and refused addresses
    apb(1'b1, 8'h04, 32'hFF);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'hFA);
    apb(1'b1, 8'h08, 32'h1F);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h1E);
    apb(1'b0, 8'h30, 32'h0);
    check(err, 1'b1);
    apb(1'b1, 8'h06, 32'h0);
    check(err, 1'b1);
    // Time stamp only when enabled
    base = cnt;
    pulse(5);
    apb(1'b1, 8'h00, 32'h1);
    pulse(5);
    check(dlt(5), 1);
    // Address matching
    apb(1'b1, 8'h10, 32'h41424344);
    apb(1'b1, 8'h14, 32'h34546);
    apb(1'b1, 8'h18, 32'h52454C59);
    apb(1'b1, 8'h1C, 32'h14141);
    check(tx_source, STA);
    rx_dest <= STA;
    rx_digi <= ALS;
    base = cnt;
    pulse(0);
    check(dlt(0) + 2 * dlt(1), 3);
    rx_dest <= ALS;
    rx_digi <= '0;
    inc_dest <= ALS;
    base = cnt;
    pulse(0);
    pulse(1);
    inc_dest <= STA;
    pulse(1);
    check(dlt(0) + dlt(1), 0);
    check(dlt(2) + 2 * dlt(4), 3);
    // Mailbox session and idle timeout
    apb(1'b1, 8'h20, 32'h41424344);
    apb(1'b1, 8'h24, 32'h34546);
    apb(1'b1, 8'h04, 32'h2);
    base = cnt;
    pulse(1);
    repeat (60) @(posedge pclk);
    check(dlt(3) + 2 * dlt(8), 3);
    base = cnt;
    pulse(8);
    repeat (60) @(posedge pclk);
    check(dlt(8), 0);
    apb(1'b0, 8'h2C, 32'h0);
    check(rd[5:4], 2'b10);
    apb(1'b1, 8'h04, 32'h0);
    base = cnt;
    pulse(1);
    repeat (60) @(posedge pclk);
    check(dlt(8), 0);
    // Mode switching, early off
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h28, 32'h1);
    check(mode, 2'b00);
    pulse(2);
    check(mode, 2'b01);
    pulse(3);
    check(mode, 2'b01);
    apb(1'b1, 8'h28, 32'h8);
    check(mode, 2'b00);
    // Early on, raw selected
    apb(1'b1, 8'h00, 32'h22);
    apb(1'b1, 8'h28, 32'h1);
    @(posedge pclk); // Hold flag follows pending by one edge
    check({pkt_hold, mode}, 3'b111);
    pulse(4);
    check(mode, 2'b00);
    apb(1'b1, 8'h28, 32'h1);
    pulse(2);
    pulse(3);
    check(mode, 2'b00);
    // Manual only
    apb(1'b1, 8'h00, 32'h6);
    apb(1'b1, 8'h28, 32'h1);
    pulse(2);
    check(mode, 2'b00);
    apb(1'b1, 8'h28, 32'h2);
    pulse(3);
    check(mode, 2'b01);
    apb(1'b1, 8'h28, 32'h4);
    check(mode, 2'b11);
    // Packet length limit, then 0 meaning 256
    apb(1'b1, 8'h0C, 32'h3);
    tid <= 8'hC3;
    base = cnt;
    repeat (6) pulse(7);
    check(dlt(6) + 16 * dlt(7), 38);
    check(pd, 8'hC3);
    apb(1'b1, 8'h0C, 32'h0);
    base = cnt;
    repeat (255) pulse(7);
    check(dlt(7), 0);
    pulse(7);
    check(dlt(7), 1);
    apb(1'b1, 8'h28, 32'h8);
    base = cnt;
    pulse(7);
    check(dlt(6), 0);
    // Null padding to the terminal
    apb(1'b1, 8'h08, 32'h2);
    apb(1'b1, 8'h00, 32'h8);
    send(8'h0D, 2);
    send(8'h0A, 0);
    apb(1'b1, 8'h00, 32'h18);
    send(8'h0A, 2);
    apb(1'b1, 8'h28, 32'h4);
    send(8'h0D, 0);
    apb(1'b1, 8'h28, 32'h2);
    send(8'h0D, 2);
    conclude();
  end
endmodule
